/* hdl/sarc_pkg.sv */
// package for the sar converter control block
// assumes a 100 MHz reference clock; the ns limits convert to cycle counts with it
package sarc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 8;
    // longest conversion, start to status high, in ns
    localparam int CONV_MAX_NS = 6000;
    // host-side least gap between conversions, in ns
    localparam int SAMPLE_MIN_NS = 1140;
    localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles per bit decision; conversion = 1 clear + 12 steps + 1 load
    localparam int STEP_CYC = 4;
    localparam int CONV_CYC = 2 + RES_W * STEP_CYC;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam logic [2:0] STEP_LAST = 3'h3;
    localparam logic [3:0] BIT_MSB = 4'hb;
    localparam logic [11:0] RES_RESET = 12'h000;
    localparam logic [3:0] NIBBLE_LOW = 4'h0;

    typedef enum logic [3:0] {
        SARC_IDLE = 4'b0001,
        SARC_CLEAR = 4'b0010,
        SARC_STEP = 4'b0100,
        SARC_LOAD = 4'b1000
    } sarc_state_e;
endpackage

/* hdl/sarc_stream_if.sv */
// valid/ready stream carrying finished results between the sar core and its fifo
// assumes both ends run on the one block clock
`timescale 1ns/10ps
interface sarc_stream_if #(parameter int W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hdl/sarc_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
// assumes a single clock and asynchronous active-low reset
`timescale 1ns/10ps
module sarc_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    sarc_stream_if.snk s_in,
    sarc_stream_if.src s_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign s_in.ready = (count != DEPTH[AW:0]);
    assign s_out.valid = (count != '0);
    assign s_out.data = mem[rd_ptr];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= s_in.data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* hdl/sarc_top.sv */
// control and output logic of a 12-bit successive-approximation converter
// assumes host strobes synchronous to i_ref_clk; comparator decision arrives on i_cmp_hi
`timescale 1ns/10ps
module sarc_top
    import sarc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_chip_sel_n,
    input wire logic i_read_n,
    input wire logic i_high_byte_select,
    input wire logic i_cmp_hi,
    input wire logic i_res_ready,
    output logic [11:0] o_data,
    output logic [11:0] o_data_oe,
    output logic o_status,
    output logic [11:0] o_approx_dac,
    output logic o_res_valid,
    output logic [11:0] o_res_data
);
    // ------------------------------------------------------------
    // host strobe decode
    // ------------------------------------------------------------
    function automatic logic [11:0] sarc_map(input logic [11:0] res, input logic hb);
        sarc_map = hb ? {res[11:8], NIBBLE_LOW, res[11:8]} : res;
    endfunction

    logic start_req;
    logic read_en;
    assign start_req = !i_chip_sel_n && !i_read_n && !i_high_byte_select;
    assign read_en = !i_chip_sel_n && !i_read_n;

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    sarc_state_e state;
    logic [2:0] step_cnt;
    logic [3:0] bit_idx;
    logic [11:0] approx_register;
    logic [11:0] result_bits;
    logic [9:0] conv_cnt;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= SARC_IDLE;
            step_cnt <= 3'h0;
            bit_idx <= BIT_MSB;
        end else begin
            case (state)
                SARC_IDLE: begin
                    if (start_req) begin
                        state <= SARC_CLEAR;
                    end
                end
                SARC_CLEAR: begin
                    state <= SARC_STEP;
                    step_cnt <= 3'h0;
                    bit_idx <= BIT_MSB;
                end
                SARC_STEP: begin
                    if (step_cnt == STEP_LAST) begin
                        step_cnt <= 3'h0;
                        if (bit_idx == 4'h0) begin
                            state <= SARC_LOAD;
                        end else begin
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end else begin
                        step_cnt <= step_cnt + 3'h1;
                    end
                end
                SARC_LOAD: begin
                    state <= SARC_IDLE;
                end
                default: begin
                    state <= SARC_IDLE;
                end
            endcase
        end
    end

    // trial bit set at the first step cycle, decided at the last, so the dac settles
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            approx_register <= RES_RESET;
        end else if (state == SARC_CLEAR) begin
            approx_register <= RES_RESET;
        end else if (state == SARC_STEP) begin
            if (step_cnt == 3'h0) begin
                approx_register[bit_idx] <= 1'b1;
            end else if (step_cnt == STEP_LAST) begin
                approx_register[bit_idx] <= i_cmp_hi;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            result_bits <= RES_RESET;
        end else if (state == SARC_LOAD) begin
            result_bits <= approx_register;
        end
    end

    // status rises at the latch-load edge; the pins show the new word one edge later
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_status <= 1'b1;
        end else begin
            o_status <= (state == SARC_IDLE && !start_req) || state == SARC_LOAD;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_approx_dac <= RES_RESET;
        end else begin
            o_approx_dac <= approx_register;
        end
    end

    // ------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------
    // the newest result is shown even mid-conversion; the latch only moves at load
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= RES_RESET;
            o_data_oe <= 12'h000;
        end else begin
            o_data <= sarc_map(result_bits, i_high_byte_select);
            o_data_oe <= {12{read_en}};
        end
    end

    // ------------------------------------------------------------
    // result stream through fifo
    // ------------------------------------------------------------
    // a full fifo drops results rather than stalling the converter, which has no wait
    sarc_stream_if #(.W(RES_W)) s_core ();
    sarc_stream_if #(.W(RES_W)) s_fifo ();
    assign s_core.valid = (state == SARC_LOAD);
    assign s_core.data = approx_register;
    assign s_fifo.ready = i_res_ready && !o_res_valid;

    sarc_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .s_in(s_core),
        .s_out(s_fifo)
    );

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_res_valid <= 1'b0;
            o_res_data <= RES_RESET;
        end else if (s_fifo.valid && s_fifo.ready) begin
            o_res_valid <= 1'b1;
            o_res_data <= s_fifo.data;
        end else if (i_res_ready) begin
            o_res_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            conv_cnt <= 10'h000;
        end else begin
            conv_cnt <= (state == SARC_IDLE) ? 10'h000 : conv_cnt + 10'h001;
        end
    end

    property p_no_start_hb;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_IDLE && i_high_byte_select) |=> state == SARC_IDLE;
    endproperty
    a_no_start_hb: assert property (p_no_start_hb) else $error("start with high byte select");

    property p_no_start_cs;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_IDLE && i_chip_sel_n) |=> state == SARC_IDLE;
    endproperty
    a_no_start_cs: assert property (p_no_start_cs) else $error("start without chip select");

    property p_start;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_IDLE && start_req) |=> state == SARC_CLEAR ##1 !o_status;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_oe;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        1'b1 |=> o_data_oe == {12{$past(!i_chip_sel_n && !i_read_n)}};
    endproperty
    a_oe: assert property (p_oe) else $error("driver enable wrong");

    property p_hb_map;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_high_byte_select |=>
            o_data == {$past(result_bits[11:8]), NIBBLE_LOW, $past(result_bits[11:8])};
    endproperty
    a_hb_map: assert property (p_hb_map) else $error("byte map wrong");

    property p_conv_len;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        conv_cnt <= 10'(CONV_MAX_CYC);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion too long");

    property p_no_restart;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_STEP && start_req) |=>
            (state == SARC_STEP && bit_idx <= $past(bit_idx)) || state == SARC_LOAD;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restart in conversion");

    property p_latch_hold;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state != SARC_LOAD) |=> $stable(result_bits);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

    property p_status_rise;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(o_status) |-> $past(state == SARC_LOAD);
    endproperty
    a_status_rise: assert property (p_status_rise) else $error("status rose early");

    property p_msb_first;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(state == SARC_STEP) |-> bit_idx == BIT_MSB;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("not msb first");

    property p_full_map;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (!i_high_byte_select) |=> o_data == $past(result_bits);
    endproperty
    a_full_map: assert property (p_full_map) else $error("word map wrong");

    property p_busy_low;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state != SARC_IDLE) |-> !o_status;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("status high while busy");

    property p_idle_high;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_IDLE) |-> o_status;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("status low while idle");

    property p_clear;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_CLEAR) |=> approx_register == RES_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("approximation not cleared");

    property p_oe_start;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_IDLE && start_req) |=> o_data_oe == 12'hfff;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("drivers off at start");

    property p_cs_quiet;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_chip_sel_n |=> o_data_oe == 12'h000;
    endproperty
    a_cs_quiet: assert property (p_cs_quiet) else $error("driven without chip select");

    property p_bit_down;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_STEP && step_cnt == STEP_LAST && bit_idx != 4'h0) |=>
            bit_idx == $past(bit_idx) - 4'h1;
    endproperty
    a_bit_down: assert property (p_bit_down) else $error("bit order wrong");

    property p_decide;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_STEP && step_cnt == STEP_LAST) |=>
            approx_register[$past(bit_idx)] == $past(i_cmp_hi);
    endproperty
    a_decide: assert property (p_decide) else $error("comparator decision lost");

    property p_load;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (state == SARC_LOAD) |=> result_bits == $past(approx_register);
    endproperty
    a_load: assert property (p_load) else $error("latch not loaded");

    c_stream_out: cover property (@(posedge i_ref_clk) o_res_valid && i_res_ready);
    c_conv: cover property (@(posedge i_ref_clk) state == SARC_LOAD);
    c_hb_read: cover property (@(posedge i_ref_clk) read_en && i_high_byte_select);
    c_busy_start: cover property (@(posedge i_ref_clk) state == SARC_STEP && start_req);
    c_fifo_full: cover property (@(posedge i_ref_clk) s_core.valid && !s_core.ready);
endmodule

/* test/sarc_host_model.sv */
// host bus and comparator model on the far side of the converter control block
// assumes the bench calls drive at a falling edge of the block clock
`timescale 1ns/10ps
module sarc_host_model
    import sarc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_status,
    input wire logic [11:0] i_level,
    input wire logic [11:0] i_approx_dac,
    output logic o_chip_sel_n,
    output logic o_read_n,
    output logic o_high_byte_select,
    output logic o_cmp_hi
);
    int idle_cyc = 0;
    // ----------------------------------------
    // comparator and host strobes
    // ----------------------------------------
    // keep the trial bit while the trial word stays at or below the level
    assign o_cmp_hi = (i_approx_dac <= i_level);
    always @(posedge i_ref_clk) begin
        idle_cyc <= i_status ? idle_cyc + 1 : 0;
    end
    initial begin
        o_chip_sel_n = 1'b1;
        o_read_n = 1'b1;
        o_high_byte_select = 1'b0;
    end
    // a start waits out the sample time; the device would not refuse an early one
    task automatic drive(input logic cs_n, input logic rd_n, input logic hbs);
        while (!cs_n && !rd_n && !hbs && i_status && idle_cyc < SAMPLE_MIN_CYC) begin
            @(negedge i_ref_clk);
        end
        o_chip_sel_n = cs_n;
        o_read_n = rd_n;
        o_high_byte_select = hbs;
    endtask
endmodule

/* test/sar_adc_parallel_read_control_tb_top.sv */
// self-checking bench for the converter control block
// assumes the host model drives strobes at falling edges and closes the comparator loop
`timescale 1ns/10ps
module sar_adc_parallel_read_control_tb_top
    import sarc_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_res_ready = 1'b1;
    logic [11:0] level = 12'h000;
    logic [11:0] prev = RES_RESET;
    logic [11:0] first_trial = 12'h000;
    logic cs_n, rd_n, hbs, cmp_hi, status, res_valid;
    logic [11:0] data, oe, dac, res_data;
    wire [11:0] pins;
    logic [11:0] got_q[$];
    logic [11:0] exp_q[$];
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int base = 0;
    int dur = 0;
    int ref_dur = 0;
    // ----------------------------------------
    // clock, block, host and monitors
    // ----------------------------------------
    always #5 i_ref_clk = ~i_ref_clk;
    for (genvar b = 0; b < 12; b++) begin : g_pin
        assign pins[b] = oe[b] ? data[b] : 1'bz;
    end
    sarc_top dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_chip_sel_n(cs_n),
        .i_read_n(rd_n), .i_high_byte_select(hbs), .i_cmp_hi(cmp_hi),
        .i_res_ready(i_res_ready), .o_data(data), .o_data_oe(oe), .o_status(status),
        .o_approx_dac(dac), .o_res_valid(res_valid), .o_res_data(res_data));
    sarc_host_model host (.i_ref_clk(i_ref_clk), .i_status(status), .i_level(level),
        .i_approx_dac(dac), .o_chip_sel_n(cs_n), .o_read_n(rd_n),
        .o_high_byte_select(hbs), .o_cmp_hi(cmp_hi));
    // the old result stays on the trial word until the clear lands, so skip it
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (res_valid && i_res_ready) begin
            got_q.push_back(res_data);
        end
        if (!status && dac != 12'h000 && dac != prev && first_trial == 12'h000) begin
            first_trial <= dac;
        end
    end
    // ----------------------------------------
    // compare and scenario tasks
    // ----------------------------------------
    task automatic chk_word(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic convert(input logic [11:0] lvl, input int again);
        first_trial = 12'h000;
        level = lvl;
        host.drive(1'b0, 1'b0, 1'b0);
        base = cyc;
        repeat (3) @(negedge i_ref_clk);
        chk_flag("status busy", 1'b0, status);
        chk_word("enables", 12'hfff, oe);
        chk_word("latched word", prev, pins);
        host.drive(1'b1, 1'b1, 1'b0);
        repeat (2) @(negedge i_ref_clk);
        chk_word("released pins", 12'hzzz, pins);
        if (again > 0) begin
            repeat (again) @(negedge i_ref_clk);
            host.drive(1'b0, 1'b0, 1'b0);
            repeat (2) @(negedge i_ref_clk);
            host.drive(1'b1, 1'b1, 1'b0);
        end
        for (int i = 0; i < 1000 && status !== 1'b1; i++) @(negedge i_ref_clk);
        dur = cyc - base;
        chk_flag("in time", 1'b1, dur <= CONV_MAX_CYC);
        chk_flag("length", 1'b1, dur == CONV_CYC + 1);
        chk_word("first trial", 12'h800, first_trial);
        if (again > 0) chk_flag("no restart", 1'b1, dur == ref_dur);
        prev = lvl;
        exp_q.push_back(lvl);
    endtask
    task automatic read_high();
        host.drive(1'b0, 1'b0, 1'b1);
        repeat (2) @(negedge i_ref_clk);
        chk_word("byte read", {prev[11:8], NIBBLE_LOW, prev[11:8]}, pins);
        chk_flag("no start", 1'b1, status);
        host.drive(1'b1, 1'b1, 1'b0);
        @(negedge i_ref_clk);
    endtask
    task automatic t_refused();
        host.drive(1'b1, 1'b0, 1'b0);
        repeat (3) @(negedge i_ref_clk);
        chk_flag("status cs high", 1'b1, status);
        chk_word("pins cs high", 12'hzzz, pins);
        host.drive(1'b0, 1'b1, 1'b1);
        repeat (3) @(negedge i_ref_clk);
        chk_flag("status read high", 1'b1, status);
        chk_word("pins read high", 12'hzzz, pins);
        host.drive(1'b1, 1'b1, 1'b0);
        $display("test refused strobes done");
    endtask
    task automatic chk_stream(input int n);
        chk_flag("stream count", 1'b1, got_q.size() == n);
        for (int k = 0; k < n; k++) chk_word("stream word", exp_q[k], got_q[k]);
        got_q.delete();
        exp_q.delete();
    endtask
    task automatic t_conversions();
        convert(12'ha5c, 0);
        ref_dur = dur;
        read_high();
        convert(12'hfff, 20);
        read_high();
        convert(12'h000, 0);
        read_high();
        chk_stream(3);
        $display("test conversions and byte reads done");
    endtask
    // converter cannot stall, so the ninth result is lost while the sink waits
    task automatic t_buffer();
        i_res_ready = 1'b0;
        for (int k = 0; k < 9; k++) convert(12'h3c1 + 12'(k), 0);
        exp_q.pop_back();
        i_res_ready = 1'b1;
        repeat (20) @(negedge i_ref_clk);
        chk_stream(8);
        chk_flag("drained", 1'b0, res_valid);
        $display("test result buffer done");
    endtask
    // a reset in mid-conversion drops the run and the latch; the next start is clean
    task automatic t_reset();
        level = 12'h5a3;
        host.drive(1'b0, 1'b0, 1'b0);
        repeat (10) @(negedge i_ref_clk);
        host.drive(1'b1, 1'b1, 1'b0);
        i_nrst = 1'b0;
        @(negedge i_ref_clk);
        chk_flag("reset status", 1'b1, status);
        chk_word("reset pins", 12'hzzz, pins);
        chk_flag("reset stream", 1'b0, res_valid);
        repeat (2) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        prev = RES_RESET;
        convert(12'h5a3, 0);
        repeat (4) @(negedge i_ref_clk);
        chk_stream(1);
        $display("test mid-run reset done");
    endtask
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        t_refused();
        t_conversions();
        t_buffer();
        t_reset();
        results();
    end
    initial begin
        #(20000 * CLK_PERIOD_NS);
        failures++;
        results();
    end
endmodule
